// file: core/wudc_top.sv
// Wake-up down counter with an AXI4-Lite register slave and a level interrupt.
// Assumes one clock, an asynchronous active-low reset and a synchronous bus master.
`include "wudc_map.svh"

module wudc_top #(
  // Clock cycles per ring oscillator tick
  parameter int unsigned TICK_DIV = `WUDC_CLK_HZ / `WUDC_TICK_HZ_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address channel
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data channel
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response channel
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address channel
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data channel
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt
  output logic irq_o
);

  localparam int unsigned TICK_W = $clog2(TICK_DIV + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

  // Write path state
  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;

  // Read path state
  logic arready_q;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Block state
  wudc_pkg::wudc_count_t interval_q;
  logic [`WUDC_LANE_W-1:0] ivl_lo_q;
  logic [`WUDC_LANE_W-1:0] ivl_hi_q;
  wudc_pkg::wudc_count_t count_q;
  wudc_pkg::wudc_count_t count_d;
  logic enable_q;
  logic expired_q;
  logic expired_d;
  logic irq_status_q;
  logic irq_mask_q;
  logic irq_q;
  logic [TICK_W-1:0] tick_cnt_q;

  // Handshakes
  wire aw_hs = s_axi_awvalid_i & awready_q;
  wire w_hs = s_axi_wvalid_i & wready_q;
  wire ar_hs = s_axi_arvalid_i & arready_q;
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;

  // Write decode
  wire wr_interval = wr_fire & (aw_addr_q == `WUDC_OFF_INTERVAL);
  wire wr_control = wr_fire & (aw_addr_q == `WUDC_OFF_CONTROL);
  wire wr_status = wr_fire & (aw_addr_q == `WUDC_OFF_IRQ_STATUS);
  wire wr_mask = wr_fire & (aw_addr_q == `WUDC_OFF_IRQ_MASK);
  wire wr_mapped = wr_interval | wr_control | wr_status | wr_mask;

  // Byte-lane write enables
  wire flag_lane = w_strb_q[`WUDC_FLAG_LANE];
  wire ivl_lo_we = wr_interval & w_strb_q[`WUDC_IVL_LO_LANE];
  wire ivl_hi_we = wr_interval & w_strb_q[`WUDC_IVL_HI_LANE];
  wire mask_we = wr_mask & flag_lane;
  wire mask_wdata = w_data_q[`WUDC_IRQ_EXPIRED_BIT];
  wire mask_next = mask_we ? mask_wdata : irq_mask_q;

  // Control byte carries the enable; an unstrobed byte leaves it alone
  wire enable_new = (wr_control & flag_lane) ? w_data_q[`WUDC_CTRL_ENABLE_BIT]
                                            : enable_q;
  wire enable_rise = enable_new & ~enable_q;
  wire enable_fall = ~enable_new & enable_q;

  // Slow tick from the clock divider stands in for the ring oscillator
  wire tick = (tick_cnt_q == TICK_LAST);

  // Expiry event is the rising edge of the flag
  wire expire_event = expired_d & ~expired_q;
  wire status_clear = wr_status & flag_lane & w_data_q[`WUDC_IRQ_EXPIRED_BIT];
  wire status_d = (irq_status_q & ~status_clear) | expire_event;

  // Read decode
  wire rd_interval = (s_axi_araddr_i == `WUDC_OFF_INTERVAL);
  wire rd_control = (s_axi_araddr_i == `WUDC_OFF_CONTROL);
  wire rd_status = (s_axi_araddr_i == `WUDC_OFF_IRQ_STATUS);
  wire rd_mask = (s_axi_araddr_i == `WUDC_OFF_IRQ_MASK);
  wire rd_mapped = rd_interval | rd_control | rd_status | rd_mask;

  // Live count while enabled, stored start value otherwise
  wire [`WUDC_COUNT_W-1:0] interval_view = enable_q ? count_q : interval_q;
  wire [31:0] ctrl_view = {30'h0, expired_q, enable_q};
  wire [31:0] rd_word = rd_interval ? {16'h0, interval_view} :
                        rd_control ? ctrl_view :
                        rd_status ? {31'h0, irq_status_q} :
                        rd_mask ? {31'h0, irq_mask_q} : 32'h0;

  // Write channel sequencing: address and data in either order
  assign aw_have_d = (aw_have_q | aw_hs) & ~wr_fire;
  assign w_have_d = (w_have_q | w_hs) & ~wr_fire;
  assign bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready_i);
  assign rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready_i);

  // Counter next value
  always_comb begin
    count_d = count_q;
    expired_d = expired_q;
    if (enable_fall) begin
      // Clearing enable zeroes the counter and the flag in the same edge
      // The clear lands on the same commit edge as enable_q; reads while disabled show the start
      // value, so the zeroed count cannot be seen from the bus
      count_d = `WUDC_COUNT_RST;
      expired_d = 1'b0;
    end else if (enable_rise) begin
      count_d = interval_q;
      expired_d = 1'b0;
    end else if (enable_q && tick && !expired_q) begin
      // Start value N takes N ticks; zero expires on the first tick
      if (count_q > `WUDC_COUNT_ONE) begin
        count_d = count_q - `WUDC_COUNT_ONE;
      end else begin
        count_d = `WUDC_COUNT_RST;
        expired_d = 1'b1;
      end
    end
  end

  // Write address and data capture
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
    end
  end

  // Write handshake outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `WUDC_RESP_OKAY;
    end else begin
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q <= ~w_have_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_mapped ? `WUDC_RESP_OKAY : `WUDC_RESP_SLVERR;
      end
    end
  end

  // Read channel; one read outstanding at a time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `WUDC_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d & ~ar_hs;
      rvalid_q <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_word;
        rresp_q <= rd_mapped ? `WUDC_RESP_OKAY : `WUDC_RESP_SLVERR;
      end
    end
  end

  // Stored start value, one instance per byte lane; a write never touches the
  // running count, and reset clears both lanes
  wudc_lane_reg #(
    .W(`WUDC_LANE_W),
    .RST(`WUDC_IVL_LANE_RST)
  ) wudc_lane_reg_lo_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(ivl_lo_we),
    .wdata_i(w_data_q[`WUDC_IVL_LO_MSB:`WUDC_IVL_LO_LSB]),
    .q_o(ivl_lo_q)
  );

  wudc_lane_reg #(
    .W(`WUDC_LANE_W),
    .RST(`WUDC_IVL_LANE_RST)
  ) wudc_lane_reg_hi_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(ivl_hi_we),
    .wdata_i(w_data_q[`WUDC_IVL_HI_MSB:`WUDC_IVL_HI_LSB]),
    .q_o(ivl_hi_q)
  );

  assign interval_q = {ivl_hi_q, ivl_lo_q};

  // Enable, flag and counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q <= 1'b0;
      expired_q <= 1'b0;
      count_q <= `WUDC_COUNT_RST;
    end else begin
      enable_q <= enable_new;
      expired_q <= expired_d;
      count_q <= count_d;
    end
  end

  // Tick divider restarts on load so the first interval is a full tick long
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
    end else if (enable_rise || tick) begin
      tick_cnt_q <= '0;
    end else if (enable_q) begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // Interrupt mask bit; it also stands for the global interrupt enable
  wudc_lane_reg #(
    .W(`WUDC_MASK_W),
    .RST(`WUDC_MASK_RST)
  ) wudc_lane_reg_mask_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(mask_we),
    .wdata_i(mask_wdata),
    .q_o(irq_mask_q)
  );

  // Sticky status, set beats clear; the level follows a mask write at once
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= status_d;
      irq_q <= status_d & mask_next;
    end
  end

  // Outputs
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign irq_o = irq_q;

endmodule

// One software-written register lane: loads on its strobe, holds otherwise
module wudc_lane_reg #(
  // Lane width and reset value
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Write strobe and data
  input wire logic we_i,
  input wire logic [W-1:0] wdata_i,
  // Stored value
  output logic [W-1:0] q_o
);

  logic [W-1:0] val_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_q <= RST;
    end else if (we_i) begin
      val_q <= wdata_i;
    end
  end

  assign q_o = val_q;

endmodule

// file: dv/wudc_top_sva.sv
// Checker for the wake-up down counter bus and interrupt ports.
// Assumes one clock domain and a master that keeps the AXI4-Lite handshakes.
module wudc_top_chk #(
  parameter int unsigned TICK_DIV = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Write channels
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // Read channels
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  wire wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;

  a_rd_latency: assert property (ar_hs |=> s_axi_rvalid_o)
    else $error("read data late");
  a_wr_latency: assert property (wr_hs |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  a_r_single: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read data repeated");
  a_b_single: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("address taken while data pending");
  a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  a_ctl_spare_zero: assert property (ar_hs && s_axi_araddr_i == 4'h4 |=>
    s_axi_rdata_o[31:2] == 30'h0) else $error("control spare bits set");
  a_count_width: assert property (ar_hs && s_axi_araddr_i == 4'h0 |=>
    s_axi_rdata_o[31:16] == 16'h0) else $error("interval wider than 16 bits");
  a_irq_drop_cause: assert property ($fell(irq_o) |->
    s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("irq fell without write");

  c_irq_rise: cover property ($rose(irq_o));
  c_write: cover property (wr_hs);
  c_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
endmodule

bind wudc_top wudc_top_chk #(.TICK_DIV(TICK_DIV)) wudc_top_chk_i (.ref_clk_i, .rst_n_i,
  .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);

// file: dv/wudc_top_test.sv
// Self-checking bench for the wake-up down counter.
// Assumes the design answers over AXI4-Lite; a short tick divider keeps runs brief.
module wudc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Wide enough that a tick never lands inside the reads just after enable
  localparam int unsigned TD = 16;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic [3:0] wr_strb = 4'hf;
  int error_cnt = 0, num_checks = 0, cyc = 0;

  wudc_top #(.TICK_DIV(TD)) wudc_top_i (.ref_clk_i, .rst_n_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .irq_o);

  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic irq_is(input logic e);
    @(negedge ref_clk_i);
    chk({31'h0, irq_o}, {31'h0, e}, "irq level");
  endtask

  task automatic rsp_is(input logic [1:0] e);
    chk({30'h0, rsp}, {30'h0, e}, "response code");
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= wr_strb;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
    end while (s_axi_bvalid_o !== 1'h1);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'h0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end while (s_axi_rvalid_o !== 1'h1);
    rd = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'h0;
  endtask

  task automatic t_reset;
    axi_rd(4'h0);
    chk(rd, 32'h0, "interval after reset");
    rsp_is(2'h0);
    axi_rd(4'h4);
    chk(rd, 32'h0, "control after reset");
    axi_rd(4'h2);
    rsp_is(2'h2);
    axi_wr(4'h2, 32'h1);
    rsp_is(2'h2);
    irq_is(1'h0);
  endtask

  task automatic t_count(input logic [15:0] n);
    axi_wr(4'hc, 32'h1);
    axi_wr(4'h0, {16'h0, n});
    rsp_is(2'h0);
    axi_wr(4'h4, 32'h1);
    axi_rd(4'h0);
    chk(rd, {16'h0, n}, "loaded count");
    axi_rd(4'h4);
    chk(rd, 32'h1, "early expiry");
    // Last look two cycles before the final tick, then just after it
    repeat (n * TD - 10) @(posedge ref_clk_i);
    axi_rd(4'h4);
    chk(rd, 32'h1, "expired a tick early");
    repeat (2) @(posedge ref_clk_i);
    axi_rd(4'h4);
    chk(rd, 32'h3, "expired");
    axi_rd(4'h0);
    chk(rd, 32'h0, "held at zero");
    irq_is(1'h1);
    axi_wr(4'hc, 32'h0);
    irq_is(1'h0);
    axi_wr(4'hc, 32'h1);
    irq_is(1'h1);
    axi_wr(4'h4, 32'h0);
    axi_rd(4'h4);
    chk(rd, 32'h0, "flag cleared");
    axi_rd(4'h0);
    chk(rd, {16'h0, n}, "stored value");
    axi_wr(4'h8, 32'h1);
    irq_is(1'h0);
    axi_rd(4'h8);
    chk(rd, 32'h0, "status cleared");
    axi_wr(4'h4, 32'h1);
    axi_rd(4'h0);
    chk(rd, {16'h0, n}, "restart reload");
    axi_wr(4'h0, 32'h1234);
    axi_rd(4'h0);
    chk(rd, {16'h0, n}, "reread of live count");
    axi_wr(4'h4, 32'h0);
    axi_rd(4'h0);
    chk(rd, 32'h1234, "start value updated");
    wr_strb = 4'h2;
    axi_wr(4'h0, 32'h5600);
    wr_strb = 4'hf;
    axi_rd(4'h0);
    chk(rd, 32'h5634, "upper lane only");
  endtask

  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    t_reset;
    t_count(16'h0001);
    t_count(16'h0004);
    stop_test;
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      stop_test;
    end
  end
endmodule

// file: shared/wudc_map.svh
// Register map, field positions, reset values and timing for the wake-up down counter.
// Assumes a 32-bit AXI4-Lite slave port with byte addresses.
`ifndef WUDC_MAP_SVH
`define WUDC_MAP_SVH

// Byte offsets of the register words
`define WUDC_OFF_INTERVAL 4'h0
`define WUDC_OFF_CONTROL 4'h4
`define WUDC_OFF_IRQ_STATUS 4'h8
`define WUDC_OFF_IRQ_MASK 4'hc
`define WUDC_ADDR_W 4

// Control word fields
`define WUDC_CTRL_ENABLE_BIT 0
`define WUDC_CTRL_EXPIRED_BIT 1

// Interrupt status and mask fields
`define WUDC_IRQ_EXPIRED_BIT 0

// Write strobe lanes and the bits they cover
`define WUDC_FLAG_LANE 0
`define WUDC_IVL_LO_LANE 0
`define WUDC_IVL_HI_LANE 1
`define WUDC_LANE_W 8
`define WUDC_IVL_LO_LSB 0
`define WUDC_IVL_LO_MSB 7
`define WUDC_IVL_HI_LSB 8
`define WUDC_IVL_HI_MSB 15
`define WUDC_MASK_W 1

// Reset values
`define WUDC_INTERVAL_RST 16'h0000
`define WUDC_IVL_LANE_RST 8'h00
`define WUDC_MASK_RST 1'h0
`define WUDC_COUNT_RST 16'h0000
`define WUDC_COUNT_ONE 16'h0001

// Counter width
`define WUDC_COUNT_W 16

// Bus responses
`define WUDC_RESP_OKAY 2'h0
`define WUDC_RESP_SLVERR 2'h2

// Clock and ring oscillator tick rate
`define WUDC_CLK_PERIOD_NS 5
`define WUDC_CLK_HZ 200000000
`define WUDC_TICK_HZ_DEFAULT 8000

`endif

// file: shared/wudc_pkg.sv
// Types shared by the wake-up down counter design.
// Assumes the constants of wudc_map.svh are included where numbers are needed.
package wudc_pkg;

  typedef logic [15:0] wudc_count_t;
  typedef logic [31:0] wudc_word_t;
  typedef logic [3:0] wudc_addr_t;

  typedef enum logic [1:0] {
    WUDC_RESP_OKAY   = 2'h0,
    WUDC_RESP_SLVERR = 2'h2
  } wudc_resp_e;

endpackage
